// ===== logic/fsc_pkg.sv
// Package for the serial flash status and configuration bit block.
// Assumes one system clock domain; the serial link arrives as plain pins.
package fsc_pkg;
  // Command opcodes
  localparam logic [7:0] OP_WREN    = 8'h06;
  localparam logic [7:0] OP_WRDI    = 8'h04;
  localparam logic [7:0] OP_WRSR1   = 8'h01;
  localparam logic [7:0] OP_WRSR2   = 8'h31;
  localparam logic [7:0] OP_WRSR3   = 8'h11;
  localparam logic [7:0] OP_RDSR1   = 8'h05;
  localparam logic [7:0] OP_RDSR2   = 8'h35;
  localparam logic [7:0] OP_RDSR3   = 8'h15;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME  = 8'h7a;
  localparam logic [7:0] OP_RST_EN  = 8'h66;
  localparam logic [7:0] OP_RST     = 8'h99;
  localparam logic [7:0] OP_PP      = 8'h02;
  localparam logic [7:0] OP_QPP     = 8'h32;
  localparam logic [7:0] OP_SE      = 8'h20;
  localparam logic [7:0] OP_BE32    = 8'h52;
  localparam logic [7:0] OP_BE64    = 8'hd8;
  localparam logic [7:0] OP_CE1     = 8'h60;
  localparam logic [7:0] OP_CE2     = 8'hc7;
  localparam logic [7:0] OP_SEC_PGM = 8'h42;
  localparam logic [7:0] OP_SEC_ERS = 8'h44;
  // Stored bit positions within the 24-bit status image
  localparam int POS_SP_LO  = 7;
  localparam int POS_BP_LO  = 2;
  localparam int POS_SP_HI  = 8;
  localparam int POS_QE     = 9;
  localparam int POS_LOCK   = 11;
  localparam int POS_CMP    = 14;
  localparam int POS_DC0    = 16;
  localparam int POS_DC1    = 17;
  localparam int POS_DRV    = 21;
  localparam int POS_HOLDRS = 23;
  // Writable stored bits per byte; lock bits handled separately
  localparam logic [7:0] WMASK_SR1 = 8'hfc;
  localparam logic [7:0] WMASK_SR2 = 8'h43;
  localparam logic [7:0] LMASK_SR2 = 8'h38;
  localparam logic [7:0] WMASK_SR3 = 8'he3;
  localparam logic [23:0] STATUS_RESET = 24'h000000;
  // Protect settings
  localparam logic [1:0] SP_SOFT = 2'b00;
  localparam logic [1:0] SP_HW   = 2'b01;
  localparam logic [1:0] SP_LOCK = 2'b10;
  // Dummy cycle counts
  localparam logic [3:0] DUMMY_QIO_0 = 4'h6;
  localparam logic [3:0] DUMMY_QIO_1 = 4'ha;
  localparam logic [3:0] DUMMY_DTR_0 = 4'h8;
  localparam logic [3:0] DUMMY_DTR_1 = 4'h6;
endpackage : fsc_pkg

// ===== logic/fsc_store.sv
// Small storage for the non-volatile status image.
// Assumes the owner presents a merged full image whenever it writes.
module fsc_store #(
  parameter int WIDTH = 24
) (
  input  wire logic             mclk_i,     // System clock
  input  wire logic             reset_n_i,  // Sync reset, loads factory image
  input  wire logic             wr_en_i,    // Write strobe
  input  wire logic [WIDTH-1:0] wr_data_i,  // Full new image
  output logic      [WIDTH-1:0] rd_data_o   // Registered image
);
  logic [WIDTH-1:0] cells;

  // Cells hold the image; reset stands in for factory state
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      cells <= fsc_pkg::STATUS_RESET;
    end else if (wr_en_i) begin
      cells <= wr_data_i;
    end
  end

  // Read data from a register, written through so it matches the cells in the same cycle
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rd_data_o <= fsc_pkg::STATUS_RESET;
    end else begin
      rd_data_o <= wr_en_i ? wr_data_i : cells;
    end
  end
endmodule : fsc_store

// ===== logic/fsc_status_bits.sv
// Status and configuration bits of a serial flash, with its status commands.
// Assumes sclk/cs/si/wp pins from outside the clock domain, mode 0 link,
// link clock well below a quarter of mclk; array core signals are synchronous.
module fsc_status_bits (
  input  wire logic       mclk_i,                   // System clock, 100 MHz
  input  wire logic       reset_n_i,                // Sync reset, active low
  input  wire logic       sclk_i,                   // Link clock pin
  input  wire logic       cs_n_i,                   // Chip select pin, active low
  input  wire logic       si_i,                     // Serial data in pin
  input  wire logic       wp_n_i,                   // Write-protect pin, active low
  input  wire logic       power_cycle_i,            // Power-down/up event pulse
  input  wire logic       erase_busy_i,             // Core is erasing
  input  wire logic       program_busy_i,           // Core is programming
  output logic            so_o,                     // Serial data out
  output logic            so_oe_o,                  // Output enable for so_o
  output logic            hold_enable_o,            // Shared pin acts as hold
  output logic            pin_reset_enable_o,       // Shared pin acts as reset
  output logic            wp_enable_o,              // Write-protect pin active
  output logic            quad_lines_enable_o,      // Lanes 2 and 3 enabled
  output logic [1:0]      drive_strength_o,         // Read driver strength code
  output logic [3:0]      quad_read_dummy_o,        // Dummy cycles, quad I/O read
  output logic [3:0]      dtr_dummy_o,              // Dummy cycles, double-rate reads
  output logic [4:0]      block_protect_field_o,    // Block protect bits
  output logic            protect_complement_o,     // Complement protect bit
  output logic [2:0]      security_lock_o,          // Security lock bits 3..1
  output logic            write_enable_latch_o,     // Write enable latch
  output logic            erase_suspended_flag_o,   // Erase suspended
  output logic            program_suspended_flag_o, // Program suspended
  output logic            status_write_start_o,     // Pulse: status write cycle
  output logic            array_cmd_start_o,        // Pulse: array op accepted
  output logic [7:0]      array_opcode_o            // Opcode of accepted op
);
  // Pin synchronisers; first stage feeds only the second
  logic sclk_meta, sclk_s, sclk_d, cs_meta, cs_s, cs_d;
  logic si_meta, si_s, wp_meta, wp_s;
  // Link capture
  logic [2:0] bit_cnt, byte_cnt;
  logic [7:0] shreg, opcode, data1, data2, rd_shift;
  logic       rd_active, reset_armed;
  logic [7:0] next_shreg;
  // Stored image and command decode
  logic [23:0] image, next_image;
  logic        image_wr;
  logic        sclk_rise, sclk_fall, cs_rise, exec;
  logic [1:0]  sp;
  logic        qe, protect_ok, wrsr_cmd, wr_accept, array_cmd, array_ok;

  function automatic logic is_array_op(input logic [7:0] op);
    is_array_op = (op == fsc_pkg::OP_PP) || (op == fsc_pkg::OP_QPP) ||
                  (op == fsc_pkg::OP_SE) || (op == fsc_pkg::OP_BE32) ||
                  (op == fsc_pkg::OP_BE64) || (op == fsc_pkg::OP_CE1) ||
                  (op == fsc_pkg::OP_CE2) || (op == fsc_pkg::OP_SEC_PGM) ||
                  (op == fsc_pkg::OP_SEC_ERS);
  endfunction : is_array_op

  function automatic logic is_wrsr(input logic [7:0] op);
    is_wrsr = (op == fsc_pkg::OP_WRSR1) || (op == fsc_pkg::OP_WRSR2) ||
              (op == fsc_pkg::OP_WRSR3);
  endfunction : is_wrsr

  // Two-flop synchronisers plus an edge stage for clock and select
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      {sclk_meta, sclk_s, sclk_d} <= 3'b000;
      {cs_meta, cs_s, cs_d}       <= 3'b111;
      {si_meta, si_s}             <= 2'b00;
      {wp_meta, wp_s}             <= 2'b11;
    end else begin
      {sclk_meta, sclk_s, sclk_d} <= {sclk_i, sclk_meta, sclk_s};
      {cs_meta, cs_s, cs_d}       <= {cs_n_i, cs_meta, cs_s};
      {si_meta, si_s}             <= {si_i, si_meta};
      {wp_meta, wp_s}             <= {wp_n_i, wp_meta};
    end
  end

  assign sclk_rise  = sclk_s & ~sclk_d & ~cs_s;
  assign sclk_fall  = ~sclk_s & sclk_d & ~cs_s;
  assign cs_rise    = cs_s & ~cs_d;
  assign next_shreg = {shreg[6:0], si_s};
  // Commands other than status reads act only when select rises on a byte boundary
  assign exec       = cs_rise && (bit_cnt == 3'h0) && (byte_cnt != 3'h0);

  // Bit and byte capture; counts clear while deselected
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || cs_s) begin
      bit_cnt  <= 3'h0;
      byte_cnt <= 3'h0;
      shreg    <= 8'h00;
    end else if (sclk_rise) begin
      shreg   <= next_shreg;
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7 && byte_cnt != 3'h7) begin
        byte_cnt <= byte_cnt + 3'h1;
      end
    end
  end

  // Opcode and the two following bytes
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      opcode <= 8'h00;
      data1  <= 8'h00;
      data2  <= 8'h00;
    end else if (sclk_rise && bit_cnt == 3'h7) begin
      case (byte_cnt)
        3'h0:    opcode <= next_shreg;
        3'h1:    data1  <= next_shreg;
        3'h2:    data2  <= next_shreg;
        default: data2  <= data2;
      endcase
    end
  end

  // Read view of the three status bytes
  function automatic logic [7:0] status_byte(input logic [7:0] op, input logic [23:0] img,
                                             input logic write_enable_latch, input logic se,
                                             input logic sp_f);
    case (op)
      fsc_pkg::OP_RDSR2: status_byte = {se, img[14:11], sp_f, img[9:8]};
      fsc_pkg::OP_RDSR3: status_byte = img[23:16];
      default:           status_byte = {img[7:2], write_enable_latch, 1'b0};
    endcase
  endfunction : status_byte

  // Status read: load after opcode, shift out on falling link edges
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || cs_s) begin
      rd_active <= 1'b0;
      rd_shift  <= 8'h00;
      so_o      <= 1'b0;
    end else if (sclk_rise && bit_cnt == 3'h7 && byte_cnt == 3'h0 &&
                 (next_shreg == fsc_pkg::OP_RDSR1 || next_shreg == fsc_pkg::OP_RDSR2 ||
                  next_shreg == fsc_pkg::OP_RDSR3)) begin
      rd_active <= 1'b1;
      rd_shift  <= status_byte(next_shreg, image, write_enable_latch_o,
                               erase_suspended_flag_o, program_suspended_flag_o);
    end else if (sclk_fall && rd_active) begin
      so_o     <= rd_shift[7];
      rd_shift <= {rd_shift[6:0], rd_shift[7]}; // Same byte repeats while selected
    end
  end

  assign so_oe_o = rd_active & ~cs_s;

  // Status write gating by protect setting and latch
  assign sp = {image[fsc_pkg::POS_SP_HI], image[fsc_pkg::POS_SP_LO]};
  assign qe = image[fsc_pkg::POS_QE];
  always_comb begin
    case (sp)
      fsc_pkg::SP_SOFT: protect_ok = 1'b1;
      fsc_pkg::SP_HW:   protect_ok = ~qe & wp_s;
      default:          protect_ok = 1'b0;
    endcase
  end
  assign wrsr_cmd  = exec && is_wrsr(opcode) && (byte_cnt >= 3'h2);
  assign wr_accept = wrsr_cmd && write_enable_latch_o && protect_ok;
  assign array_cmd = exec && is_array_op(opcode);
  // Security register ops pick their register from address byte bits 5:4
  assign array_ok  = write_enable_latch_o &&
                     !(((opcode == fsc_pkg::OP_SEC_PGM) || (opcode == fsc_pkg::OP_SEC_ERS)) &&
                       (data2[5:4] != 2'b00) && security_lock_o[data2[5:4] - 2'b01]);

  // Merge written bytes into the image; lock bits only ever set
  always_comb begin
    next_image = image;
    image_wr   = 1'b0;
    if (power_cycle_i) begin
      image_wr = (sp == fsc_pkg::SP_LOCK);
      next_image[fsc_pkg::POS_SP_HI] = 1'b0;
      next_image[fsc_pkg::POS_SP_LO] = 1'b0;
    end else if (wr_accept) begin
      image_wr = 1'b1;
      case (opcode)
        fsc_pkg::OP_WRSR1: begin
          next_image[7:0] = data1 & fsc_pkg::WMASK_SR1;
          if (byte_cnt >= 3'h3) begin
            next_image[15:8] = (data2 & fsc_pkg::WMASK_SR2) |
                               ((data2 | image[15:8]) & fsc_pkg::LMASK_SR2);
          end
        end
        fsc_pkg::OP_WRSR2: next_image[15:8] = (data1 & fsc_pkg::WMASK_SR2) |
                                              ((data1 | image[15:8]) & fsc_pkg::LMASK_SR2);
        default: next_image[23:16] = data1 & fsc_pkg::WMASK_SR3;
      endcase
    end
  end

  fsc_store #(
    .WIDTH (24)
  ) u_store (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .wr_en_i   (image_wr),
    .wr_data_i (next_image),
    .rd_data_o (image)
  );

  // Write enable latch; power cycle wins over any command
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || power_cycle_i) begin
      write_enable_latch_o <= 1'b0;
    end else if (exec && opcode == fsc_pkg::OP_WREN && byte_cnt == 3'h1) begin
      write_enable_latch_o <= 1'b1;
    end else if (exec && (opcode == fsc_pkg::OP_WRDI ||
                          (opcode == fsc_pkg::OP_RST && reset_armed))) begin
      write_enable_latch_o <= 1'b0;
    end else if (wr_accept || (array_cmd && array_ok)) begin
      write_enable_latch_o <= 1'b0;                        // Consumed by the operation
    end
  end

  // Software reset arms on one command, fires on the next
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      reset_armed <= 1'b0;
    end else if (exec) begin
      reset_armed <= (opcode == fsc_pkg::OP_RST_EN);
    end
  end

  // Suspend flags: erase takes precedence when both could apply
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || power_cycle_i ||
        (exec && (opcode == fsc_pkg::OP_RESUME ||
                  (opcode == fsc_pkg::OP_RST && reset_armed)))) begin
      erase_suspended_flag_o   <= 1'b0;
      program_suspended_flag_o <= 1'b0;
    end else if (exec && opcode == fsc_pkg::OP_SUSPEND) begin
      if (erase_busy_i) begin
        erase_suspended_flag_o <= 1'b1;
      end else if (program_busy_i) begin
        program_suspended_flag_o <= 1'b1;
      end
    end
  end

  // Operation start pulses toward the array core
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      status_write_start_o <= 1'b0;
      array_cmd_start_o    <= 1'b0;
      array_opcode_o       <= 8'h00;
    end else begin
      status_write_start_o <= wr_accept && !power_cycle_i;
      array_cmd_start_o    <= array_cmd && array_ok;
      if (array_cmd && array_ok) begin
        array_opcode_o <= opcode;
      end
    end
  end

  // Pin function and configuration decode from the stored image
  assign hold_enable_o         = ~qe & ~image[fsc_pkg::POS_HOLDRS];
  assign pin_reset_enable_o    = ~qe & image[fsc_pkg::POS_HOLDRS];
  assign wp_enable_o           = ~qe;
  assign quad_lines_enable_o   = qe;
  assign drive_strength_o      = image[fsc_pkg::POS_DRV +: 2];
  assign quad_read_dummy_o     = image[fsc_pkg::POS_DC0] ? fsc_pkg::DUMMY_QIO_1
                                                         : fsc_pkg::DUMMY_QIO_0;
  assign dtr_dummy_o           = image[fsc_pkg::POS_DC1] ? fsc_pkg::DUMMY_DTR_1
                                                         : fsc_pkg::DUMMY_DTR_0;
  assign block_protect_field_o = image[fsc_pkg::POS_BP_LO +: 5];
  assign protect_complement_o  = image[fsc_pkg::POS_CMP];
  assign security_lock_o       = image[fsc_pkg::POS_LOCK +: 3];

  // Checks
  property p_pin_mux;
    @(posedge mclk_i) disable iff (!reset_n_i)
      quad_lines_enable_o |-> !hold_enable_o && !pin_reset_enable_o && !wp_enable_o;
  endproperty
  a_pin_mux: assert property (p_pin_mux) else $error("pin function active with quad on");

  property p_hold_sel;
    @(posedge mclk_i) disable iff (!reset_n_i)
      !quad_lines_enable_o |-> (hold_enable_o != pin_reset_enable_o);
  endproperty
  a_hold_sel: assert property (p_hold_sel) else $error("shared pin function not unique");

  property p_dummy;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (quad_read_dummy_o == 4'h6 || quad_read_dummy_o == 4'ha) &&
      (dtr_dummy_o == 4'h8 || dtr_dummy_o == 4'h6) &&
      ((quad_read_dummy_o == 4'ha) == image[16]) && ((dtr_dummy_o == 4'h6) == image[17]);
  endproperty
  a_dummy: assert property (p_dummy) else $error("dummy cycle count wrong");

  property p_lock_sticky;
    @(posedge mclk_i) disable iff (!reset_n_i)
      ##1 ((security_lock_o & $past(security_lock_o)) == $past(security_lock_o));
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("security lock bit cleared");

  property p_refused;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (wrsr_cmd && !wr_accept && !power_cycle_i) |=> !status_write_start_o && $stable(image) &&
                                                     $stable(write_enable_latch_o);
  endproperty
  a_refused: assert property (p_refused) else $error("refused status write took effect");

  property p_wel_needed;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (status_write_start_o || array_cmd_start_o) |-> $past(write_enable_latch_o) &&
                                                      !write_enable_latch_o;
  endproperty
  a_wel_needed: assert property (p_wel_needed) else $error("write without latch");

  property p_locked_modes;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (wrsr_cmd && (sp[1] || (sp == 2'b01 && (qe || !wp_s)))) |=> !status_write_start_o;
  endproperty
  a_locked_modes: assert property (p_locked_modes) else $error("locked register written");

  property p_power_unlock;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (power_cycle_i && sp == 2'b10) |-> ##2 (sp == 2'b00) && !erase_suspended_flag_o &&
                                            !program_suspended_flag_o;
  endproperty
  a_power_unlock: assert property (p_power_unlock) else $error("power cycle left lock");

  property p_resume;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (exec && opcode == 8'h7a) |=> !erase_suspended_flag_o && !program_suspended_flag_o;
  endproperty
  a_resume: assert property (p_resume) else $error("resume left suspend flag");

  property p_suspend;
    @(posedge mclk_i) disable iff (!reset_n_i)
      (exec && opcode == 8'h75 && erase_busy_i && !power_cycle_i) |=> erase_suspended_flag_o;
  endproperty
  a_suspend: assert property (p_suspend) else $error("erase suspend flag not set");

  c_write_ok: cover property (@(posedge mclk_i) disable iff (!reset_n_i) wr_accept);
  c_write_refused: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
                                   wrsr_cmd && !wr_accept);
  c_status_read: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
                                 rd_active && sclk_fall);
  c_lock_set: cover property (@(posedge mclk_i) disable iff (!reset_n_i)
                              $rose(security_lock_o[0]));
endmodule : fsc_status_bits

// ===== test/fsc_host_model.sv
// Host side of the serial link: issues status commands in mode 0.
// Assumes one caller at a time; link clock stands low outside frames.
module fsc_host_model (
  input  wire logic mclk_i,  // System clock, paces the link
  input  wire logic so_i,    // Serial data from the device
  output logic      sclk_o,  // Link clock, 80 ns period in frames
  output logic      cs_n_o,  // Chip select, active low
  output logic      si_o     // Serial data to the device
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o   = 1'b0;
  end
  // Four system cycles per half bit; read data is taken late in the high
  // phase, where the device output has long settled after the last fall
  task automatic xfer(input logic [31:0] bits, input int n, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge mclk_i);
    cs_n_o <= 1'b0;
    si_o   <= bits[31];
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge mclk_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge mclk_i);
      rd = {rd[6:0], so_i};
      sclk_o <= 1'b0;
      if (i < 31) si_o <= bits[30 - i];
    end
    repeat (2) @(posedge mclk_i);
    cs_n_o <= 1'b1;
    si_o   <= ~si_o;  // Released line must not keep showing the last bit
    repeat (12) @(posedge mclk_i);
  endtask : xfer
endmodule : fsc_host_model

// ===== test/tb_top.sv
// Bench for the status bit block: status commands over the link, checks at pins.
// Assumes the host model owns the link; core busy and power events come from here.
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk_i, reset_n_i, wp_n_i, power_cycle_i, erase_busy_i, program_busy_i;
  logic       sclk, cs_n, si, so, soe, write_enable_latch, es, ps, hold, prst, wpe, qe, cmp, sws, acs;
  logic [4:0] bpf;
  logic [1:0] drv;
  logic [3:0] qrd, dtd;
  logic [2:0] lock;
  logic [7:0] aop, r;
  int         err_count, tests_run, sw_cnt, ar_cnt, cyc, n, oe_cnt;
  fsc_status_bits fsc_status_bits_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .sclk_i(sclk),
    .cs_n_i(cs_n), .si_i(si), .wp_n_i(wp_n_i), .power_cycle_i(power_cycle_i),
    .erase_busy_i(erase_busy_i), .program_busy_i(program_busy_i), .so_o(so), .so_oe_o(soe),
    .hold_enable_o(hold), .pin_reset_enable_o(prst), .wp_enable_o(wpe),
    .quad_lines_enable_o(qe), .drive_strength_o(drv), .quad_read_dummy_o(qrd),
    .dtr_dummy_o(dtd), .block_protect_field_o(bpf), .protect_complement_o(cmp),
    .security_lock_o(lock), .write_enable_latch_o(write_enable_latch), .erase_suspended_flag_o(es),
    .program_suspended_flag_o(ps), .status_write_start_o(sws), .array_cmd_start_o(acs),
    .array_opcode_o(aop));
  fsc_host_model fsc_host_model_i (.mclk_i(mclk_i), .so_i(so), .sclk_o(sclk), .cs_n_o(cs_n),
    .si_o(si));
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  // Pulse counters and a ceiling far above the expected run of some 5.5k cycles
  always @(posedge mclk_i) begin
    cyc++;
    if (sws === 1'b1) sw_cnt++;
    if (acs === 1'b1) ar_cnt++;
    if (soe === 1'b1) oe_cnt++;
    if (cyc == 40000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks run %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic cmd(input logic [31:0] b, input int nb);
    fsc_host_model_i.xfer(b, nb, r);
  endtask : cmd
  // Write enable followed by a one-byte status write
  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    cmd(32'h06000000, 8);
    cmd({op, d, 16'h0000}, 16);
  endtask : wr
  task automatic pwr();
    @(posedge mclk_i) power_cycle_i <= 1'b1;
    @(posedge mclk_i) power_cycle_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
  endtask : pwr
  initial begin
    reset_n_i = 1'b0;
    wp_n_i = 1'b1;
    power_cycle_i = 1'b0;
    erase_busy_i = 1'b0;
    program_busy_i = 1'b0;
    repeat (16) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    `CHK(dtd, 4'h8)
    `CHK(qrd, 4'h6)
    `CHK({hold, prst, wpe, qe, drv}, 6'h28)
    `CHK({cmp, lock}, 4'h0)
    // Partial byte and a write without the latch both change nothing
    cmd(32'h06000000, 12);
    `CHK(write_enable_latch, 1'b0)
    cmd(32'h31020000, 16);
    `CHK(qe, 1'b0)
    `CHK(sw_cnt, 0)
    for (int i = 0; i < 4; i++) begin
      wr(8'h11, {1'b1, 2'(i), 5'h03});
      `CHK(drv, 2'(i))
    end
    `CHK({hold, prst}, 2'b01)
    `CHK({qrd, dtd}, 8'ha6)
    `CHK({write_enable_latch, 28'(sw_cnt)}, 29'h4)
    fsc_host_model_i.xfer(32'h15000000, 16, r);
    `CHK(r, 8'he3)
    wr(8'h11, 8'h00);
    `CHK({hold, prst, qrd, dtd}, 10'h268)
    wr(8'h31, 8'h4a);
    `CHK({cmp, lock, qe}, 5'h13)
    `CHK({hold, prst, wpe}, 3'b000)
    fsc_host_model_i.xfer(32'h35000000, 16, r);
    `CHK(r, 8'h4a)
    // Output enable only while a read shifts: 64 to 72 cycles per 16-bit read
    `CHK(oe_cnt > 127 && oe_cnt < 145, 1'b1)
    wr(8'h31, 8'h00);
    `CHK({cmp, lock, wpe, hold}, 6'h07)
    // Security program: locked index refused, latch needed, open index taken
    cmd(32'h06000000, 8);
    cmd(32'h42101000, 32);
    `CHK(ar_cnt, 0)
    // Refused op left the latch set; drop it before the no-latch attempt
    cmd(32'h04000000, 8);
    `CHK(write_enable_latch, 1'b0)
    cmd(32'h42202000, 32);
    `CHK(ar_cnt, 0)
    cmd(32'h06000000, 8);
    cmd(32'h42202000, 32);
    `CHK({aop, 8'(ar_cnt)}, 16'h4201)
    // Suspend flags set and cleared by each documented means
    @(posedge mclk_i) erase_busy_i <= 1'b1;
    cmd(32'h75000000, 8);
    `CHK({es, ps}, 2'b10)
    cmd(32'h7a000000, 8);
    `CHK(es, 1'b0)
    @(posedge mclk_i) erase_busy_i <= 1'b0;
    program_busy_i <= 1'b1;
    cmd(32'h75000000, 8);
    `CHK({es, ps}, 2'b01)
    cmd(32'h66000000, 8);
    cmd(32'h99000000, 8);
    `CHK(ps, 1'b0)
    cmd(32'h75000000, 8);
    // Lock-down until power cycle; refused write keeps latch and bits
    cmd(32'h06000000, 8);
    cmd(32'h01080100, 24);
    `CHK(bpf, 5'h02)
    n = sw_cnt;
    wr(8'h11, 8'h20);
    `CHK({drv, write_enable_latch, 8'(sw_cnt - n)}, 11'h100)
    pwr();
    fsc_host_model_i.xfer(32'h35000000, 16, r);
    `CHK(r, 8'h08)
    `CHK({ps, write_enable_latch}, 2'b00)
    `CHK(oe_cnt > 191 && oe_cnt < 217, 1'b1)
    // Hardware protection follows the pin while quad lines are off
    wr(8'h01, 8'h8c);
    fsc_host_model_i.xfer(32'h05000000, 16, r);
    `CHK({r, bpf}, 13'h1183)
    @(posedge mclk_i) wp_n_i <= 1'b0;
    wr(8'h11, 8'h20);
    `CHK(drv, 2'b00)
    @(posedge mclk_i) wp_n_i <= 1'b1;
    wr(8'h11, 8'h20);
    `CHK(drv, 2'b01)
    wr(8'h31, 8'h0a);
    n = sw_cnt;
    wr(8'h11, 8'h40);
    `CHK({qe, drv, 8'(sw_cnt - n)}, 11'h500)
    give_verdict();
  end
endmodule : tb_top
